// ===== dra_rx_alarm_regs.vh
// Register indices, field positions, reset values for the receive alarm block
// Assumes byte address = 4 * index on a 32-bit register bus
`ifndef DRA_RX_ALARM_REGS_VH
`define DRA_RX_ALARM_REGS_VH

// ************************************************
// Register indices (word address)
// ************************************************
`define DRA_IDX_RX_CONFIG        6'h0e
`define DRA_IDX_RX_FAR_END_STS   6'h0f
`define DRA_IDX_RX_INT_ENABLE    6'h10
`define DRA_IDX_RX_INT_STATUS    6'h11
`define DRA_IDX_RX_FAR_END_CODE  6'h12
`define DRA_IDX_RX_MODE          6'h30

// ************************************************
// Event bit positions in enable and status
// ************************************************
`define DRA_EV_CP_ERR    7
`define DRA_EV_LOS       6
`define DRA_EV_AIS       5
`define DRA_EV_IDLE      4
`define DRA_EV_FERF      3
`define DRA_EV_FMT       2
`define DRA_EV_OOF       1
`define DRA_EV_P_ERR     0

// ************************************************
// Far-end status fields
// ************************************************
`define DRA_STS_FERF_BIT 4
`define DRA_STS_FMT_BIT  3
`define DRA_FEBE_ERRORS  3'h3
`define DRA_FEBE_CLEAN   3'h7

// ************************************************
// Reset values
// ************************************************
`define DRA_RST_CODE     6'h3f
`define DRA_RST_CFG      4'h0
`define DRA_RST_EN       8'h00
`define DRA_RST_STS      8'h00
`define DRA_RST_MODE     1'h0

// ************************************************
// Format detection figures
// ************************************************
`define DRA_FMT_WINDOW   15
`define DRA_FMT_ZEROS    2
`define DRA_FMT_ONES     63

// ************************************************
// Bus responses
// ************************************************
`define DRA_RESP_OKAY    2'h0
`define DRA_RESP_SLVERR  2'h2

`endif

// ===== dra_format_detect.v
// Framing format detector fed one application-id bit per M-frame
// Assumes strobe and bit come from framer logic on mclk
`timescale 1ns/10ps
`include "dra_rx_alarm_regs.vh"

module dra_format_detect
#(
   parameter WINDOW = `DRA_FMT_WINDOW,
   parameter ONES   = `DRA_FMT_ONES
)
(
   input  wire              mclk,
   input  wire              rst_n,
   input  wire              mframe_stb,
   input  wire              aic_bit,
   output reg               fmt_q
);

   reg  [WINDOW-1:0] hist_q;
   reg  [6:0]        ones_q;
   wire [WINDOW-1:0] hist_d;
   wire [6:0]        ones_d;

   // Zero count over the history window
   function [4:0] count_zeros;
      input [WINDOW-1:0] v;
      integer i;
      begin
         count_zeros = 5'h00;
         for (i = 0; i < WINDOW; i = i + 1)
            count_zeros = count_zeros + {4'h0, ~v[i]};
      end
   endfunction

   // Saturating run of ones keeps the counter small
   assign hist_d = {hist_q[WINDOW-2:0], aic_bit};
   assign ones_d = !aic_bit ? 7'h00 :
                   (ones_q >= ONES[6:0]) ? ones_q : ones_q + 7'h01;

   // ************************************************
   // History, run length and validated format
   // ************************************************
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hist_q <= {WINDOW{1'b1}};
         ones_q <= 7'h00;
         fmt_q  <= 1'b0;
      end
      else if (mframe_stb)
      begin
         hist_q <= hist_d;
         ones_q <= ones_d;
         if (count_zeros(hist_d) >= `DRA_FMT_ZEROS)
            fmt_q <= 1'b0;
         else if (ones_d >= ONES[6:0])
            fmt_q <= 1'b1;
      end
   end

endmodule // dra_format_detect

// ===== dra_rx_alarm_top.v
// Receive alarm, far-end status and event interrupt registers on AXI4-Lite
// Assumes framer alarm levels and error strobes arrive on mclk
// Notes on behaviour
// - Status bit 4 shows live far-end failure
// - Two zero id bits in 15 frames: M13
// - 63 consecutive one id bits: C-bit parity
// - Status bits 2..0 hold latest block-error value
// - Value 011 means remote errors, 111 none
// - Block-error value and alarm code update only in C-bit mode
// - CP-bit error interrupt gated by enable bit 7
// - Change interrupts gated by enable bits 6..1
// - P-bit error interrupt gated by enable bit 0
// - Status bit 7 latches CP errors, read clears
// - Alarm change bits latch, read clears them
// - Status bit 2 latches format change, read clears
// - Status bit 0 latches P errors, read clears
// - Code bits 6..1 reversed, reset to ones
// - Config bits 7..4 show live alarms
`timescale 1ns/10ps
`include "dra_rx_alarm_regs.vh"

module dra_rx_alarm_top
#(
   parameter ADDR_W = 8
)
(
   input  wire              mclk,
   input  wire              rst_n,
   // AXI4-Lite slave
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // Framer alarm levels
   input  wire              loss_of_signal,
   input  wire              alarm_indication,
   input  wire              idle_detect,
   input  wire              out_of_frame,
   input  wire              far_end_failure_state,
   // Framer error strobes
   input  wire              cp_err_stb,
   input  wire              p_err_stb,
   // Application-id bit, one per M-frame
   input  wire              mframe_stb,
   input  wire              aic_bit,
   // Block-error value and validated alarm code
   input  wire              febe_stb,
   input  wire [2:0]        far_end_block_error_value,
   input  wire              code_valid_stb,
   input  wire [5:0]        received_alarm_control_code,
   // Outputs to framer and host
   output reg  [3:0]        rx_cfg_q,
   output reg               cbit_mode_q,
   output reg               format_indication_state,
   output reg               remote_err_q,
   output reg               irq_q
);

   // ************************************************
   // Declarations
   // ************************************************
   reg  [7:0]        int_en_q;
   reg  [7:0]        int_sts_q;
   reg  [7:0]        int_sts_d;
   reg  [2:0]        febe_q;
   reg  [5:0]        code_q;
   reg  [5:0]        prev_q;
   reg  [ADDR_W-1:0] awaddr_q;
   reg  [31:0]       wdata_q;
   reg  [3:0]        wstrb_q;
   reg               aw_full_q;
   reg               w_full_q;
   reg  [31:0]       rd_val;
   reg               rd_hit;
   wire              fmt_w;
   wire [5:0]        cur_w;
   wire [7:0]        ev_set;
   wire              aw_take;
   wire              w_take;
   wire              ar_take;
   wire              do_wr;
   wire              aw_full_d;
   wire              w_full_d;
   wire              bvalid_d;
   wire              rvalid_d;
   wire [5:0]        wr_idx;
   wire [5:0]        rd_idx;
   wire              wr_lane0;
   wire              sts_read;

   // Word index of a byte address
   function [5:0] word_idx;
      input [ADDR_W-1:0] a;
      begin
         word_idx = a[7:2];
      end
   endfunction

   // Low byte into a 32-bit read word, upper bits zero
   function [31:0] byte_word;
      input [7:0] b;
      begin
         byte_word = {24'h000000, b};
      end
   endfunction

   // ************************************************
   // Format detection
   // ************************************************
   dra_format_detect
   #(
      .WINDOW (`DRA_FMT_WINDOW),
      .ONES   (`DRA_FMT_ONES)
   )
   u_fmt
   (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .mframe_stb (mframe_stb),
      .aic_bit    (aic_bit),
      .fmt_q      (fmt_w)
   );

   // ************************************************
   // Event detection
   // ************************************************
   // Current tracked levels, ordered los ais idle ferf fmt oof
   assign cur_w = {loss_of_signal, alarm_indication, idle_detect,
                   far_end_failure_state, fmt_w, out_of_frame};

   // Levels compared with last cycle give change events
   assign ev_set[`DRA_EV_CP_ERR] = cp_err_stb;
   assign ev_set[`DRA_EV_LOS]    = cur_w[5] ^ prev_q[5];
   assign ev_set[`DRA_EV_AIS]    = cur_w[4] ^ prev_q[4];
   assign ev_set[`DRA_EV_IDLE]   = cur_w[3] ^ prev_q[3];
   assign ev_set[`DRA_EV_FERF]   = cur_w[2] ^ prev_q[2];
   assign ev_set[`DRA_EV_FMT]    = cur_w[1] ^ prev_q[1];
   assign ev_set[`DRA_EV_OOF]    = cur_w[0] ^ prev_q[0];
   assign ev_set[`DRA_EV_P_ERR]  = p_err_stb;

   // Previous levels; out of frame starts declared
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= 6'h01;
      else
         prev_q <= cur_w;
   end

   // ************************************************
   // Bus handshakes
   // ************************************************
   assign aw_take   = s_axi_awvalid & s_axi_awready;
   assign w_take    = s_axi_wvalid & s_axi_wready;
   assign ar_take   = s_axi_arvalid & s_axi_arready;
   assign do_wr     = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign aw_full_d = ~do_wr & (aw_full_q | aw_take);
   assign w_full_d  = ~do_wr & (w_full_q | w_take);
   assign bvalid_d  = do_wr | (s_axi_bvalid & ~s_axi_bready);
   assign rvalid_d  = ar_take | (s_axi_rvalid & ~s_axi_rready);
   assign wr_idx    = word_idx(awaddr_q);
   assign rd_idx    = word_idx(s_axi_araddr);
   assign wr_lane0  = do_wr & wstrb_q[0];
   assign sts_read  = ar_take & (rd_idx == `DRA_IDX_RX_INT_STATUS);

   // Address and data may arrive in either order
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         awaddr_q      <= {ADDR_W{1'b0}};
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
      end
      else
      begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         if (aw_take)
            awaddr_q <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         // Ready only while the slot is free and no answer waits
         s_axi_awready <= ~aw_full_d & ~bvalid_d;
         s_axi_wready  <= ~w_full_d & ~bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid  <= rvalid_d;
      end
   end

   // Write response; unmapped addresses answer with an error
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         s_axi_bresp <= `DRA_RESP_OKAY;
      else if (do_wr)
      begin
         case (wr_idx)
            `DRA_IDX_RX_CONFIG,
            `DRA_IDX_RX_FAR_END_STS,
            `DRA_IDX_RX_INT_ENABLE,
            `DRA_IDX_RX_INT_STATUS,
            `DRA_IDX_RX_FAR_END_CODE,
            `DRA_IDX_RX_MODE: s_axi_bresp <= `DRA_RESP_OKAY;
            default:          s_axi_bresp <= `DRA_RESP_SLVERR;
         endcase
      end
   end

   // ************************************************
   // Writable registers
   // ************************************************
   // Only byte lane 0 carries register bits; read-only targets ignored
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_cfg_q    <= `DRA_RST_CFG;
         int_en_q    <= `DRA_RST_EN;
         cbit_mode_q <= `DRA_RST_MODE;
      end
      else if (wr_lane0)
      begin
         case (wr_idx)
            `DRA_IDX_RX_CONFIG:     rx_cfg_q    <= wdata_q[3:0];
            `DRA_IDX_RX_INT_ENABLE: int_en_q    <= wdata_q[7:0];
            `DRA_IDX_RX_MODE:       cbit_mode_q <= wdata_q[0];
            default:                rx_cfg_q    <= rx_cfg_q;
         endcase
      end
   end

   // ************************************************
   // Far-end values
   // ************************************************
   // Held values only refresh in C-bit parity mode
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         febe_q       <= 3'h0;
         code_q       <= `DRA_RST_CODE;
         remote_err_q <= 1'b0;
      end
      else if (cbit_mode_q)
      begin
         if (febe_stb)
         begin
            febe_q <= far_end_block_error_value;
            // Other codes leave the remote flag as it was
            if (far_end_block_error_value == `DRA_FEBE_ERRORS)
               remote_err_q <= 1'b1;
            else if (far_end_block_error_value == `DRA_FEBE_CLEAN)
               remote_err_q <= 1'b0;
         end
         if (code_valid_stb)
            code_q <= received_alarm_control_code;
      end
   end

   // Validated format mirrored to the framer
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         format_indication_state <= 1'b0;
      else
         format_indication_state <= fmt_w;
   end

   // ************************************************
   // Sticky status and interrupt
   // ************************************************
   // A new event in the clearing cycle survives the read
   always @*
   begin
      int_sts_d = int_sts_q;
      if (sts_read)
         int_sts_d = 8'h00;
      int_sts_d = int_sts_d | ev_set;
   end

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         int_sts_q <= `DRA_RST_STS;
      else
         int_sts_q <= int_sts_d;
   end

   // Each source gated by its enable; registered to keep the pin clean
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_q <= 1'b0;
      else
         irq_q <= (int_sts_d[`DRA_EV_CP_ERR] & int_en_q[`DRA_EV_CP_ERR]) |
                  (|(int_sts_d[6:1] & int_en_q[6:1])) |
                  (int_sts_d[`DRA_EV_P_ERR] & int_en_q[`DRA_EV_P_ERR]);
   end

   // ************************************************
   // Read path
   // ************************************************
   // Read word for the addressed register
   always @*
   begin
      rd_val = 32'h00000000;
      rd_hit = 1'b1;
      case (rd_idx)
         `DRA_IDX_RX_CONFIG:
            rd_val = byte_word({alarm_indication, loss_of_signal,
                                idle_detect, out_of_frame, rx_cfg_q});
         `DRA_IDX_RX_FAR_END_STS:
            rd_val = byte_word({3'h0, far_end_failure_state,
                                fmt_w, febe_q});
         `DRA_IDX_RX_INT_ENABLE:
            rd_val = byte_word(int_en_q);
         `DRA_IDX_RX_INT_STATUS:
            rd_val = byte_word(int_sts_q);
         `DRA_IDX_RX_FAR_END_CODE:
            rd_val = byte_word({1'b0, code_q[0], code_q[1], code_q[2],
                                code_q[3], code_q[4], code_q[5], 1'b0});
         `DRA_IDX_RX_MODE:
            rd_val = byte_word({7'h00, cbit_mode_q});
         default:
            rd_hit = 1'b0;
      endcase
   end

   // Data captured at the address handshake
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DRA_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? `DRA_RESP_OKAY : `DRA_RESP_SLVERR;
      end
   end

endmodule // dra_rx_alarm_top

// ===== dra_rx_alarm_props.sv
// Concurrent checks on the receive alarm block ports
// Assumes one mclk domain and the bind below onto the top module
`timescale 1ns/10ps
module dra_rx_alarm_props
(
   input wire       mclk,
   input wire       rst_n,
   input wire       s_axi_awvalid,
   input wire       s_axi_awready,
   input wire       s_axi_wvalid,
   input wire       s_axi_wready,
   input wire       s_axi_bvalid,
   input wire       s_axi_arvalid,
   input wire       s_axi_arready,
   input wire       s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire       mframe_stb,
   input wire       aic_bit,
   input wire       febe_stb,
   input wire [2:0] far_end_block_error_value,
   input wire       cbit_mode_q,
   input wire       remote_err_q,
   input wire       format_indication_state
);
   reg [5:0]  ones_q;
   reg [14:0] hist_q;
   wire       febe_live;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // ************************************************
   // Shadow of the id bit history
   // ************************************************
   assign febe_live = febe_stb & cbit_mode_q;

   // Run of ones saturates so a long C-bit stream never wraps
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ones_q <= 6'h00;
         hist_q <= 15'h7fff;
      end
      else if (mframe_stb)
      begin
         hist_q <= {hist_q[13:0], aic_bit};
         ones_q <= !aic_bit ? 6'h00 : (ones_q == 6'h3f ? 6'h3f : ones_q + 6'h01);
      end
   end

   // ************************************************
   // Properties
   // ************************************************
   a_fmt_set_run: assert property ($rose(format_indication_state) |-> ones_q == 6'h3f)
      else $error("format set without a full run of ones");
   a_fmt_clr_zeros: assert property ($fell(format_indication_state) |-> $countones(hist_q) <= 13)
      else $error("format cleared without two zeros in window");
   a_febe_remote_err: assert property (febe_live && far_end_block_error_value == 3'h3 |=> remote_err_q)
      else $error("error value did not flag remote errors");
   a_febe_remote_ok: assert property (febe_live && far_end_block_error_value == 3'h7 |=> !remote_err_q)
      else $error("clean value did not clear remote errors");
   a_febe_mode_gate: assert property ($changed(remote_err_q) |-> $past(febe_live))
      else $error("remote error flag moved outside c-bit capture");
   a_rd_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_rd_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer_two: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                     |-> ##2 s_axi_bvalid)
      else $error("write answer late");
endmodule // dra_rx_alarm_props

bind dra_rx_alarm_top dra_rx_alarm_props u_props (.*);

// ===== dra_rx_alarm_bench.sv
// Self-checking bench for the receive alarm register block
// Assumes the design top and the checker bind are compiled first
`timescale 1ns/10ps
`include "dra_rx_alarm_regs.vh"
module dra_rx_alarm_bench;
   localparam [7:0] A_CFG = 8'h38, A_STS = 8'h3c, A_EN = 8'h40, A_INT = 8'h44, A_CODE = 8'h48, A_MODE = 8'hc0;
   reg         mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg [7:0]   s_axi_awaddr, s_axi_araddr, en, evm;
   reg [31:0]  s_axi_wdata;
   reg [3:0]   s_axi_wstrb;
   reg         loss_of_signal, alarm_indication, idle_detect, out_of_frame, far_end_failure_state;
   reg         cp_err_stb, p_err_stb, mframe_stb, aic_bit, febe_stb, code_valid_stb;
   reg [2:0]   far_end_block_error_value;
   reg [5:0]   received_alarm_control_code, c;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [3:0]  rx_cfg_q;
   wire        cbit_mode_q, format_indication_state, remote_err_q, irq_q;
   integer     fail_count = 0, tests_run = 0, cyc = 0, i;
   reg [31:0]  exp_q[$];

   dra_rx_alarm_top u_dut (.*);

   // ************************************************
   // Clock, checking and closing
   // ************************************************
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   task tally_and_finish;
      begin
         $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   // Read data is matched against the oldest note
   always @(posedge mclk)
      if (s_axi_rvalid && s_axi_rready)
         chk(s_axi_rdata, exp_q.pop_front());

   // Hang guard, far above the expected run length
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         fail_count = fail_count + 1;
         tally_and_finish;
      end
   end

   // ************************************************
   // Bus and framer drivers
   // ************************************************
   task wr(input [7:0] a, input [31:0] d, input [1:0] r);
      begin
         @(posedge mclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         // Only the hang guard ends a wait for the answer
         do
         begin
            @(posedge mclk);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
         end
         while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
         chk({30'h0, s_axi_bresp}, {30'h0, r});
      end
   endtask

   // Expected value is noted before the request goes out
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge mclk);
         exp_q.push_back(e);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do
         begin
            @(posedge mclk);
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
         end
         while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
         // Only the unmapped probe address answers with an error
         chk({30'h0, s_axi_rresp}, {30'h0, (a == 8'h20) ? `DRA_RESP_SLVERR : `DRA_RESP_OKAY});
      end
   endtask

   // One event source: strobes pulse, alarm levels toggle
   task ev(input integer k);
      begin
         @(posedge mclk);
         case (k)
            7: cp_err_stb <= 1'b1;
            6: loss_of_signal <= ~loss_of_signal;
            5: alarm_indication <= ~alarm_indication;
            4: idle_detect <= ~idle_detect;
            3: far_end_failure_state <= ~far_end_failure_state;
            1: out_of_frame <= ~out_of_frame;
            0: p_err_stb <= 1'b1;
         endcase
         @(posedge mclk);
         cp_err_stb <= 1'b0;
         p_err_stb <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask

   task fr(input b);
      begin
         @(posedge mclk);
         mframe_stb <= 1'b1;
         aic_bit <= b;
         @(posedge mclk);
         mframe_stb <= 1'b0;
      end
   endtask

   // Block-error value and alarm code arrive together
   task fe(input [2:0] v, input [5:0] k);
      begin
         @(posedge mclk);
         febe_stb <= 1'b1;
         code_valid_stb <= 1'b1;
         far_end_block_error_value <= v;
         received_alarm_control_code <= k;
         @(posedge mclk);
         febe_stb <= 1'b0;
         code_valid_stb <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial
   begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {loss_of_signal, alarm_indication, idle_detect, far_end_failure_state} = 4'h0;
      out_of_frame = 1'b1;
      {cp_err_stb, p_err_stb, mframe_stb, aic_bit, febe_stb, code_valid_stb} = 6'h00;
      far_end_block_error_value = 3'h0;
      received_alarm_control_code = 6'h00;
      void'($urandom(37383));
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rd(A_CFG, 32'h10);
      rd(A_STS, 32'h0);
      rd(A_EN, 32'h0);
      rd(A_INT, 32'h0);
      rd(A_CODE, {24'h0, 1'b0, `DRA_RST_CODE, 1'b0});
      rd(A_MODE, 32'h0);
      rd(8'h20, 32'h0);
      wr(A_STS, 32'hff, `DRA_RESP_OKAY);
      wr(A_CODE, 32'hff, `DRA_RESP_OKAY);
      wr(8'h24, 32'h1, `DRA_RESP_SLVERR);
      rd(A_STS, 32'h0);
      rd(A_CODE, 32'h7e);
      // Config low nibble writable through byte lane 0 only
      wr(A_CFG, 32'h5a, `DRA_RESP_OKAY);
      s_axi_wstrb <= 4'he;
      wr(A_CFG, 32'h05, `DRA_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(A_CFG, 32'h1a);
      chk({28'h0, rx_cfg_q}, 32'ha);
      wr(A_EN, 32'hff, `DRA_RESP_OKAY);
      rd(A_EN, 32'hff);
      // Each source but format alone sets its bit; one read clears it
      for (i = 0; i < 8; i = i + 1)
         if (i != 2)
         begin
            ev(i);
            chk({31'h0, irq_q}, 32'h1);
            rd(A_INT, 32'h1 << i);
            rd(A_INT, 32'h0);
            repeat (2) @(posedge mclk);
            chk({31'h0, irq_q}, 32'h0);
         end
      // Event in the very cycle of the clearing read must survive
      fork
         rd(A_INT, 32'h0);
         begin
            @(posedge mclk);
            p_err_stb <= 1'b1;
            @(posedge mclk);
            p_err_stb <= 1'b0;
         end
      join
      rd(A_INT, 32'h1);
      rd(A_CFG, 32'hea);
      rd(A_STS, 32'h10);
      // Random masks against random event sets
      repeat (6)
      begin
         en = $urandom;
         evm = $urandom & 8'hfb;
         wr(A_EN, {24'h0, en}, `DRA_RESP_OKAY);
         for (i = 0; i < 8; i = i + 1)
            if (evm[i])
               ev(i);
         chk({31'h0, irq_q}, {31'h0, |(en & evm)});
         rd(A_INT, {24'h0, evm});
      end
      // Format detection: 62 ones short, 63rd sets, two zeros clear
      wr(A_EN, 32'h04, `DRA_RESP_OKAY);
      wr(A_MODE, 32'h1, `DRA_RESP_OKAY);
      chk({31'h0, cbit_mode_q}, 32'h1);
      repeat (62) fr(1'b1);
      repeat (3) @(posedge mclk);
      chk({31'h0, format_indication_state}, 32'h0);
      fr(1'b1);
      repeat (3) @(posedge mclk);
      chk({31'h0, format_indication_state}, 32'h1);
      chk({31'h0, irq_q}, 32'h1);
      rd(A_INT, 32'h04);
      rd(A_STS, {27'h0, far_end_failure_state, 4'h8});
      fr(1'b0);
      repeat (5) fr(1'b1);
      chk({31'h0, format_indication_state}, 32'h1);
      fr(1'b0);
      repeat (3) @(posedge mclk);
      chk({31'h0, format_indication_state}, 32'h0);
      rd(A_INT, 32'h04);
      // Far-end fields captured in c-bit mode only
      c = $urandom;
      fe(3'h3, c);
      chk({31'h0, remote_err_q}, 32'h1);
      rd(A_STS, {27'h0, far_end_failure_state, 4'h3});
      fe(3'h7, c);
      chk({31'h0, remote_err_q}, 32'h0);
      rd(A_CODE, {25'h0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0});
      wr(A_MODE, 32'h0, `DRA_RESP_OKAY);
      chk({31'h0, cbit_mode_q}, 32'h0);
      fe(3'h3, ~c);
      chk({31'h0, remote_err_q}, 32'h0);
      rd(A_STS, {27'h0, far_end_failure_state, 4'h7});
      rd(A_CODE, {25'h0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0});
      tally_and_finish;
   end
endmodule // dra_rx_alarm_bench
